// File: hdl/mains_power_supervisor.v
// Mains power supervisor: firing, tick, failure and sequencing
// Contract
// - Tick is zero crossings divided by 10 for 50 Hz, 12 for 60 Hz.
// - Each gate fires at a phase angle after the detected zero crossing.
// - Optionally pick 50/60 Hz at startup by measuring crossing interval.
// - Crossing timeout declares mains failure and raises power-fail.
// - Gate conduction above a limit fraction signals brown-out power-fail.
// - While power-fail is raised all gates stay on continuously until reset asserts.
// - After power-fail wait the hold-up delay, then assert reset.
// - Once reset asserts, gates off until supplies decay below threshold.
// - Switch-off runs the same shutdown but indicates warm start.
// - When mains is stable, assert reset before supplies; cold start keeps its value.
// - Wait for crossing, enable three supplies in turn, later release reset.
`timescale 1ns/1ps
`default_nettype none
`include "mps_consts.vh"
module mains_power_supervisor #(
  parameter CNT_W        = `MPS_CNT_W,
  parameter LEVEL_W      = `MPS_LEVEL_W,
  parameter AUTO_FREQ    = 1,
  parameter ZC_TIMEOUT   = `MPS_ZC_TIMEOUT_CYC,
  parameter BROWN_PCT    = `MPS_BROWN_LIMIT_PCT,
  parameter HOLDUP       = `MPS_HOLDUP_CYC,
  parameter RELEASE      = `MPS_RELEASE_CYC,
  parameter DECAY_LEVEL  = `MPS_DECAY_LEVEL,
  parameter TARGET_LEVEL = `MPS_TARGET_LEVEL
) (
  input  wire               ref_clk,
  input  wire               sys_rst,
  input  wire               line_zero_cross_in,
  input  wire               freq60Strap,
  input  wire               powerSwitchOn,
  input  wire [LEVEL_W-1:0] raw_logic_supply_level,
  input  wire [LEVEL_W-1:0] raw_high_supply_level,
  output reg  [2:0]         rectGate,
  output reg                tick10Hz,
  output reg                powerFailIrq,
  output reg                systemReset,
  output reg                coldStart
);
  localparam [2:0] ST_WAIT_STABLE = 3'h0;
  localparam [2:0] ST_WAIT_CROSS  = 3'h1;
  localparam [2:0] ST_ENABLE      = 3'h2;
  localparam [2:0] ST_RUN         = 3'h3;
  localparam [2:0] ST_HOLDUP      = 3'h4;
  localparam [2:0] ST_DECAY       = 3'h5;
  localparam [CNT_W-1:0] TIMEOUT_C = ZC_TIMEOUT[CNT_W-1:0];
  localparam [CNT_W-1:0] HOLDUP_C  = HOLDUP[CNT_W-1:0];
  localparam [CNT_W-1:0] RELEASE_C = RELEASE[CNT_W-1:0];
  localparam             SPLIT_I   = `MPS_FREQ_SPLIT_CYC;
  localparam [CNT_W-1:0] SPLIT_C   = SPLIT_I[CNT_W-1:0];
  localparam [LEVEL_W-1:0] DECAY_C  = DECAY_LEVEL[LEVEL_W-1:0];
  localparam [LEVEL_W-1:0] TARGET_C = TARGET_LEVEL[LEVEL_W-1:0];

  // Two-stage synchronisers for pins
  reg [1:0] zcSync;
  reg [1:0] strapSync;
  reg [1:0] switchSync;
  reg       zcLast;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zcSync     <= 2'h0;
      strapSync  <= 2'h0;
      switchSync <= 2'h0;
      zcLast     <= 1'b0;
    end else begin
      zcSync     <= {zcSync[0], line_zero_cross_in};
      strapSync  <= {strapSync[0], freq60Strap};
      switchSync <= {switchSync[0], powerSwitchOn};
      zcLast     <= zcSync[1];
    end
  end
  wire crossPulse = zcSync[1] != zcLast;
  wire switchOn   = switchSync[1];

  // Crossing interval measurement and loss timeout
  reg [CNT_W-1:0] sinceCross;
  reg [CNT_W-1:0] halfPeriod;
  reg             mainsLost;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sinceCross <= {CNT_W{1'b0}};
      halfPeriod <= SPLIT_C;
      mainsLost  <= 1'b1;
    end else if (crossPulse) begin
      halfPeriod <= sinceCross;
      sinceCross <= {CNT_W{1'b0}};
      mainsLost  <= 1'b0;
    end else begin
      if (sinceCross != TIMEOUT_C) begin
        sinceCross <= sinceCross + 1'b1;
      end else begin
        mainsLost <= 1'b1;
      end
    end
  end

  // Frequency choice latched once after 16 stable crossings, strap or measured
  reg       freqKnown;
  reg       is60;
  reg [7:0] stableCount;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      freqKnown   <= 1'b0;
      is60        <= 1'b0;
      stableCount <= 8'h00;
    end else begin
      if (mainsLost) begin
        stableCount <= 8'h00;
      end else if (crossPulse && stableCount != `MPS_STABLE_CROSSES) begin
        stableCount <= stableCount + 8'h01;
      end
      if (!freqKnown && stableCount == `MPS_STABLE_CROSSES) begin
        freqKnown <= 1'b1;
        if (AUTO_FREQ != 0) begin
          is60 <= halfPeriod < SPLIT_C;
        end else begin
          is60 <= strapSync[1];
        end
      end
    end
  end
  wire mainsStable = freqKnown && !mainsLost &&
                     stableCount == `MPS_STABLE_CROSSES;

  // 10 Hz tick: one full cycle is two crossings
  reg [3:0] tickCount;
  wire [3:0] tickLimit = is60 ? {`MPS_DIV_60HZ, 1'b0} : {`MPS_DIV_50HZ, 1'b0};
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCount <= 4'h0;
      tick10Hz  <= 1'b0;
    end else begin
      tick10Hz <= 1'b0;
      if (crossPulse && freqKnown) begin
        if (tickCount == tickLimit - 4'h1) begin
          tickCount <= 4'h0;
          tick10Hz  <= 1'b1;
        end else begin
          tickCount <= tickCount + 4'h1;
        end
      end
    end
  end

  // Phase-angle regulation for the two regulated raw supplies
  wire [1:0]       phaseGate;
  wire [CNT_W-1:0] delayLogic;
  wire [CNT_W-1:0] delayHigh;
  mps_phase_gate #(.CNT_W(CNT_W), .LEVEL_W(LEVEL_W),
                   .PULSE(`MPS_GATE_PULSE_CYC)) uLogic (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .crossPulse(crossPulse),
    .halfPeriod(halfPeriod), .level(raw_logic_supply_level),
    .target(TARGET_C), .gate(phaseGate[0]), .delay(delayLogic));
  mps_phase_gate #(.CNT_W(CNT_W), .LEVEL_W(LEVEL_W),
                   .PULSE(`MPS_GATE_PULSE_CYC)) uHigh (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .crossPulse(crossPulse),
    .halfPeriod(halfPeriod), .level(raw_high_supply_level),
    .target(TARGET_C), .gate(phaseGate[1]), .delay(delayHigh));

  // Conduction fraction = 1 - delay/halfPeriod; brown-out if above limit
  wire [CNT_W+6:0] hpScaled  = halfPeriod * (7'd100 - BROWN_PCT[6:0]);
  wire [CNT_W+6:0] dlScaled  = {7'h00, delayLogic} * 7'd100;
  wire [CNT_W+6:0] dhScaled  = {7'h00, delayHigh} * 7'd100;
  wire             brownOut  = dlScaled < hpScaled || dhScaled < hpScaled;

  reg [2:0]       state;
  reg [CNT_W-1:0] timer;
  reg [1:0]       enIndex;
  reg [2:0]       enabled;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_WAIT_STABLE;
      timer        <= {CNT_W{1'b0}};
      enIndex      <= 2'h0;
      enabled      <= 3'h0;
      powerFailIrq <= 1'b0;
      systemReset  <= 1'b1;
      coldStart    <= 1'b1;
    end else begin
      case (state)
        ST_WAIT_STABLE: begin
          enabled <= 3'h0;
          if (mainsStable && switchOn) begin
            powerFailIrq <= 1'b0;
            systemReset  <= 1'b1;
            state        <= ST_WAIT_CROSS;
          end
        end
        ST_WAIT_CROSS: begin
          if (crossPulse) begin
            state   <= ST_ENABLE;
            enIndex <= 2'h0;
            timer   <= {CNT_W{1'b0}};
          end
        end
        ST_ENABLE: begin
          timer <= timer + 1'b1;
          if (crossPulse && enIndex != 2'h3) begin
            enabled[enIndex] <= 1'b1;
            enIndex          <= enIndex + 2'h1;
          end
          if (enIndex == 2'h3 && timer >= RELEASE_C) begin
            systemReset <= 1'b0;
            state       <= ST_RUN;
          end
          if (mainsLost) begin
            powerFailIrq <= 1'b1;
            coldStart    <= 1'b1;
            timer        <= {CNT_W{1'b0}};
            state        <= ST_HOLDUP;
          end
        end
        ST_RUN: begin
          if (mainsLost || brownOut || !switchOn) begin
            powerFailIrq <= 1'b1;
            coldStart    <= switchOn;
            timer        <= {CNT_W{1'b0}};
            state        <= ST_HOLDUP;
          end
        end
        ST_HOLDUP: begin
          timer <= timer + 1'b1;
          if (timer >= HOLDUP_C) begin
            systemReset <= 1'b1;
            enabled     <= 3'h0;
            state       <= ST_DECAY;
          end
        end
        ST_DECAY: begin
          if (raw_logic_supply_level <= DECAY_C &&
              raw_high_supply_level <= DECAY_C) begin
            state <= ST_WAIT_STABLE;
          end
        end
        default: state <= ST_WAIT_STABLE;
      endcase
    end
  end

  // Gate drive: full-on during power-fail, off during decay and while waiting for stable mains
  wire [2:0] phaseSel = {phaseGate[1], phaseGate[1], phaseGate[0]};
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rectGate <= 3'h0;
    end else if (state == ST_DECAY || state == ST_WAIT_STABLE) begin
      rectGate <= 3'h0;
    end else if (powerFailIrq) begin
      rectGate <= 3'h7;
    end else begin
      rectGate <= enabled & phaseSel;
    end
  end
endmodule
`default_nettype wire

// File: hdl/mps_phase_gate.v
// Phase-angle gate timer for one rectifier supply
`timescale 1ns/1ps
`default_nettype none
module mps_phase_gate #(
  parameter CNT_W   = 24,
  parameter LEVEL_W = 8,
  parameter PULSE   = 4000
) (
  input  wire               ref_clk,
  input  wire               sys_rst,
  input  wire               crossPulse,
  input  wire [CNT_W-1:0]   halfPeriod,
  input  wire [LEVEL_W-1:0] level,
  input  wire [LEVEL_W-1:0] target,
  output reg                gate,
  output reg  [CNT_W-1:0]   delay
);
  reg [CNT_W-1:0] sinceCross;
  reg [CNT_W-1:0] step;

  always @* begin
    step = halfPeriod >> 6;
  end

  // Delay tracks the level: low supply fires earlier, high fires later
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sinceCross <= {CNT_W{1'b0}};
      delay      <= {CNT_W{1'b1}};
      gate       <= 1'b0;
    end else begin
      if (crossPulse) begin
        sinceCross <= {CNT_W{1'b0}};
        // Pull a reset or stale delay back inside the half cycle
        if (delay > halfPeriod) begin
          delay <= halfPeriod;
        end else if (level < target && delay > step) begin
          delay <= delay - step;
        end else if (level > target && delay < halfPeriod - step) begin
          delay <= delay + step;
        end
      end else if (sinceCross != {CNT_W{1'b1}}) begin
        sinceCross <= sinceCross + 1'b1;
      end
      gate <= (sinceCross >= delay) &&
              (sinceCross < delay + PULSE[CNT_W-1:0]);
    end
  end
endmodule
`default_nettype wire

// File: inc/mps_consts.vh
// Constants for the mains power supervisor
`ifndef MPS_CONSTS_VH
`define MPS_CONSTS_VH
`define MPS_CLK_HZ          40000000
`define MPS_DIV_50HZ        3'h5
`define MPS_DIV_60HZ        3'h6
`define MPS_ZC_TIMEOUT_US   25000
`define MPS_ZC_TIMEOUT_CYC  ((`MPS_ZC_TIMEOUT_US * (`MPS_CLK_HZ / 1000000)))
`define MPS_FREQ_SPLIT_US   9100
`define MPS_FREQ_SPLIT_CYC  ((`MPS_FREQ_SPLIT_US * (`MPS_CLK_HZ / 1000000)))
`define MPS_HOLDUP_MS       20
`define MPS_HOLDUP_CYC      ((`MPS_HOLDUP_MS * (`MPS_CLK_HZ / 1000)))
`define MPS_RELEASE_MS      100
`define MPS_RELEASE_CYC     ((`MPS_RELEASE_MS * (`MPS_CLK_HZ / 1000)))
`define MPS_GATE_PULSE_US   100
`define MPS_GATE_PULSE_CYC  ((`MPS_GATE_PULSE_US * (`MPS_CLK_HZ / 1000000)))
`define MPS_BROWN_LIMIT_PCT 90
`define MPS_LEVEL_W         8
`define MPS_TARGET_LEVEL    8'hb0
`define MPS_DECAY_LEVEL     8'h20
`define MPS_STABLE_CROSSES  8'h10
`define MPS_CNT_W           24
`endif

// File: tb/mains_power_supervisor_test.sv
// Self-checking bench for the mains power supervisor
`timescale 1ns/1ps
`default_nettype none
module mains_power_supervisor_test;
  localparam int HALF = 600;
  localparam int TMO  = 1500;
  localparam int HOLD = 500;
  logic       ref_clk, sys_rst, mainsOn, freq60Strap, powerSwitchOn;
  logic       zc, zcSeen, tick10Hz, powerFailIrq, systemReset, coldStart;
  logic [7:0] lvLogic, lvHigh;
  logic [2:0] rectGate;
  int         mismatches, n_compared, edges, t, gateOn, e0, g0;
  mains_power_supervisor #(.AUTO_FREQ(0), .ZC_TIMEOUT(TMO), .HOLDUP(HOLD),
    .RELEASE(1000)) u_mains_power_supervisor (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .line_zero_cross_in(zc), .freq60Strap(freq60Strap),
    .powerSwitchOn(powerSwitchOn), .raw_logic_supply_level(lvLogic),
    .raw_high_supply_level(lvHigh), .rectGate(rectGate),
    .tick10Hz(tick10Hz), .powerFailIrq(powerFailIrq),
    .systemReset(systemReset), .coldStart(coldStart));
  mps_mains_model #(.HALF(HALF)) u_mps_mains_model (.ref_clk(ref_clk),
    .mainsOn(mainsOn), .rectGate(rectGate), .zeroCross(zc),
    .logicLevel(lvLogic), .highLevel(lvHigh));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    zcSeen <= zc;
    if (zc !== zcSeen)
      edges <= edges + 1;
    if (rectGate[0] === 1'b1)
      gateOn <= gateOn + 1;
  end
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return systemReset;
      1: return powerFailIrq;
      default: return tick10Hz;
    endcase
  endfunction
  // Bounded wait for an output level; t holds the cycles spent
  task automatic await(input int k, input logic v, input int lim);
    t = 0;
    while (pick(k) !== v && t < lim) begin
      step();
      t++;
    end
  endtask
  task automatic power_up(input logic strap);
    sys_rst = 1'b1;
    freq60Strap = strap;
    mainsOn = 1'b1;
    powerSwitchOn = 1'b1;
    repeat (20) step();
    sys_rst = 1'b0;
    step();
    check("reset", 1, systemReset);
    check("cold", 1, coldStart);
    check("gates", 0, rectGate);
    await(0, 0, 30000);
    check("release", 0, systemReset);
    check("late enough", 1, t >= 18 * HALF);
    check("irq", 0, powerFailIrq);
  endtask
  task automatic ticks(input int n);
    await(2, 1, 20 * HALF);
    e0 = edges;
    g0 = gateOn;
    step();
    await(2, 1, 20 * HALF);
    check("crossings per tick", n, edges - e0);
    g0 = gateOn - g0;
    check("phase firing", 1, g0 > 0 && g0 < n * HALF);
  endtask
  task automatic mains_fail;
    mainsOn = 1'b0;
    await(1, 1, 4 * TMO);
    check("timeout irq", 1, t >= TMO - HALF && powerFailIrq);
    step();
    check("gates full", 7, rectGate);
    await(0, 1, 2 * HOLD);
    check("holdup", 1, t >= HOLD - 8 && t <= HOLD + 8);
    check("cold", 1, coldStart);
    mainsOn = 1'b1;
    step();
    check("gates off", 0, rectGate);
    t = 0;
    while ((lvLogic > 8'h20 || lvHigh > 8'h20) && t < 9000) begin
      check("gates off", 0, rectGate);
      step();
      t++;
    end
    check("irq held", 1, powerFailIrq);
    await(0, 0, 30000);
    check("irq cleared", 0, powerFailIrq);
  endtask
  task automatic switch_off;
    powerSwitchOn = 1'b0;
    await(1, 1, 100);
    check("switch irq", 1, powerFailIrq);
    await(0, 1, 2 * HOLD);
    check("switch reset", 1, systemReset);
    check("warm start", 0, coldStart);
  endtask
  initial begin
    power_up(1'b0);
    ticks(10);
    mains_fail;
    switch_off;
    power_up(1'b1);
    ticks(12);
    conclude;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    conclude;
  end
endmodule
`default_nettype wire

// File: tb/mps_mains_model.sv
// Mains stage model: zero-cross wave and raw supply levels
`timescale 1ns/1ps
`default_nettype none
module mps_mains_model #(
  parameter HALF = 600
) (
  input  wire logic       ref_clk,
  input  wire logic       mainsOn,
  input  wire logic [2:0] rectGate,
  output var  logic       zeroCross,
  output var  logic [7:0] logicLevel,
  output var  logic [7:0] highLevel
);
  int   phase;
  logic leak;
  assign leak = (phase[3:0] == 4'h0);
  // Charge while gated, slow leak otherwise
  function automatic logic [7:0] nxt(input logic on, input logic [7:0] v);
    if (on && v < 8'hd0)
      return v + 8'h1;
    return (leak && v != 8'h0) ? v - 8'h1 : v;
  endfunction
  initial begin
    phase = 0;
    zeroCross = 1'b0;
    logicLevel = 8'h0;
    highLevel = 8'h0;
  end
  always @(posedge ref_clk) begin
    phase <= (phase == HALF - 1) ? 0 : phase + 1;
    if (mainsOn && phase == HALF - 1)
      zeroCross <= ~zeroCross;
    logicLevel <= nxt(mainsOn && rectGate[0], logicLevel);
    highLevel <= nxt(mainsOn && |rectGate[2:1], highLevel);
  end
endmodule
`default_nettype wire

// File: tb/mps_monitor.sv
// Port assertions for the mains power supervisor
`timescale 1ns/1ps
`default_nettype none
module mps_monitor #(
  parameter ZC_TIMEOUT = 1500
) (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       line_zero_cross_in,
  input wire logic       powerSwitchOn,
  input wire logic [2:0] rectGate,
  input wire logic       tick10Hz,
  input wire logic       powerFailIrq,
  input wire logic       systemReset,
  input wire logic       coldStart
);
  logic [23:0] idle;
  logic        zcLast;
  // Cycles since the line last changed
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle <= 24'h0;
      zcLast <= 1'b0;
    end else begin
      zcLast <= line_zero_cross_in;
      if (line_zero_cross_in != zcLast)
        idle <= 24'h0;
      else if (idle != 24'hffffff)
        idle <= idle + 24'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_fail_start;
    $rose(powerFailIrq) && !systemReset;
  endsequence
  sequence s_hold;
    (!systemReset)[*8] ##[1:600] systemReset;
  endsequence
  a_tick_single: assert property (tick10Hz |=> !tick10Hz)
    else $error("tick wider than one cycle");
  a_timeout_fail: assert property (
    idle == 24'(ZC_TIMEOUT + 16) && !systemReset |-> powerFailIrq)
    else $error("no power fail after crossing timeout");
  a_gates_full: assert property (
    powerFailIrq && $past(powerFailIrq) && !systemReset |-> rectGate == 3'h7)
    else $error("gates not all on during power fail");
  a_holdup_wait: assert property (s_fail_start |-> s_hold)
    else $error("reset not asserted after hold-up");
  a_gates_off: assert property (
    powerFailIrq && systemReset && $past(systemReset) |-> rectGate == 3'h0)
    else $error("gates on after shutdown reset");
  a_warm_flag: assert property (
    $rose(systemReset) && powerFailIrq |-> coldStart == powerSwitchOn)
    else $error("cold or warm indication wrong");
  a_start_order: assert property (
    $past(rectGate) == 3'h0 && rectGate != 3'h0 && !powerFailIrq
    && $past(systemReset) |-> systemReset && coldStart)
    else $error("supply enabled without reset and cold start");
  a_irq_keep: assert property (
    $fell(powerFailIrq) |-> systemReset && $past(systemReset))
    else $error("power fail dropped outside power-up");
endmodule
bind mains_power_supervisor mps_monitor #(.ZC_TIMEOUT(ZC_TIMEOUT))
  u_mps_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .line_zero_cross_in(line_zero_cross_in), .powerSwitchOn(powerSwitchOn),
  .rectGate(rectGate), .tick10Hz(tick10Hz), .powerFailIrq(powerFailIrq),
  .systemReset(systemReset), .coldStart(coldStart));
`default_nettype wire
